// File: shared/async_serial_port_pkg.sv
// Constants, field positions and state types of the asynchronous serial port
package async_serial_port_pkg;

	// Register addresses on the CPU register port
	localparam logic [7:0] MODE_ADDR   = 8'h70;
	localparam logic [7:0] BAUD_ADDR   = 8'h71;
	localparam logic [7:0] TXS_ADDR    = 8'h72;
	localparam logic [7:0] STATUS_ADDR = 8'h73;
	localparam logic [7:0] RXB_ADDR    = 8'h74;

	// Mode control field positions
	localparam int POWER_BIT = 7;
	localparam int TXEN_BIT  = 6;
	localparam int RXEN_BIT  = 5;
	localparam int PAR_HI    = 4;
	localparam int PAR_LO    = 3;
	localparam int CLEN_BIT  = 2;
	localparam int STOP_BIT  = 1;

	// Error status field positions
	localparam int PE_BIT  = 2;
	localparam int FE_BIT  = 1;
	localparam int OVE_BIT = 0;

	// Baud control fields: prescale select above, 5-bit divisor below
	localparam int PRE_HI = 7;
	localparam int PRE_LO = 5;
	localparam int DIV_HI = 4;

	// Reset values
	localparam logic [7:0] MODE_RESET   = 8'h01;
	localparam logic [7:0] BAUD_RESET   = 8'h1F;
	localparam logic [7:0] BUF_RESET    = 8'hFF;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO    = 8'h00;

	// Parity selections
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD  = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;

	// Rate limit: bit time is two divisor periods of the base clock
	localparam int         CLK_HZ  = 25_000_000;
	localparam int         MAX_BPS = 625_000;
	localparam logic [4:0] K_MIN   = 5'((CLK_HZ + 2 * MAX_BPS - 1) / (2 * MAX_BPS));

	// Last data bit index for 8- and 7-bit characters
	localparam logic [2:0] LAST8 = 3'h7;
	localparam logic [2:0] LAST7 = 3'h6;

	typedef enum logic [2:0] {
		TX_IDLE   = 3'h0,
		TX_START  = 3'h1,
		TX_DATA   = 3'h3,
		TX_PARITY = 3'h2,
		TX_STOP1  = 3'h6,
		TX_STOP2  = 3'h7
	} tx_state_e;

	typedef enum logic [2:0] {
		RX_IDLE   = 3'h0,
		RX_START  = 3'h1,
		RX_DATA   = 3'h3,
		RX_PARITY = 3'h2,
		RX_STOP   = 3'h6
	} rx_state_e;

endpackage

// File: design/async_serial_port.sv
// Full-duplex asynchronous serial port with CPU register port and baud generator
`timescale 1ns/1ns

// Notes on behaviour
// - Power bit clear halts port, saving power
// - Rate limited to at most 625 kbps
// - 7 or 8 data bits, LSB first
// - Own 5-bit baud rate divisor
// - Transmit and receive run independently
// - Stopped clock freezes every register
// - Stopped clock keeps serial output level
// - Enable set synchronised to baud base clock, clear acts at once
// - Full character moves into receive buffer
// - 7-bit data fills bits 0-6, top zero
// - Overrun keeps old receive buffer content
// - Receive buffer readable, writes ignored
// - Reset or power off fills buffer with ones
// - Receive shifter hidden from software
// - Transmit write loads and starts sending
// - Transmit register write only, reads zero
// - Reset, power or enable off fill ones
// - Power off resets logic and status
// - Enable clear resets its own path
// - Parity none, zero, odd or even
// - Two stop bits on transmit only
module async_serial_port
	import async_serial_port_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       stopClock,
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrEn,
	input  wire logic       regRdEn,
	input  wire logic [7:0] regWrData,
	output logic      [7:0] regRdData,
	input  wire logic       serialInPin,
	output logic            serialOutPin,
	output logic            txDone,
	output logic            rxDone
);

	logic [7:0] modeReg;
	logic [7:0] baudCtrlReg;
	logic [7:0] rxBufReg;
	logic [7:0] txShiftReg;
	logic [7:0] errReg;
	logic       rxFullReg;
	logic       rxSync1_reg;
	logic       rxSync2_reg;
	logic [7:0] presc_reg;
	logic       baseTick_reg;
	logic       txEnSync_reg;
	logic       rxEnSync_reg;
	tx_state_e  txState_reg;
	logic [4:0] txCnt_reg;
	logic       txHalf_reg;
	logic [2:0] txBit_reg;
	logic       txPar_reg;
	rx_state_e  rxState_reg;
	logic [4:0] rxCnt_reg;
	logic       rxHalf_reg;
	logic [2:0] rxBit_reg;
	logic [7:0] rxShift_reg;
	logic       rxPar_reg;
	logic [7:0] outAge_reg;

	logic       powerEn;
	logic       rxLine;
	logic [4:0] kEff;
	logic [2:0] lastBit;
	logic [1:0] parSel;
	logic       txReset;
	logic       rxReset;
	logic       txHalfDone;
	logic       txBitDone;
	logic       rxHalfDone;
	logic       rxBitDone;
	logic       txLoad;
	logic       rxComplete;
	logic [7:0] rxData;
	logic [2:0] rxErrNew;
	logic       rdStatus;
	logic       rdBuffer;

	// Address match, used for the write and read-strobe decodes; the read data mux uses a case
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = (addr == target);
	endfunction

	// Low bits of the prescaler that must all be one for a base tick
	function automatic logic [7:0] tickMask(input logic [2:0] sel);
		tickMask = ~(8'hFF << sel);
	endfunction

	// Power off parks the receive input high so no false start is seen
	assign powerEn  = modeReg[POWER_BIT];
	assign rxLine   = powerEn ? rxSync2_reg : 1'b1;
	// Divisor below the floor would exceed the maximum rate
	assign kEff     = (baudCtrlReg[DIV_HI:0] < K_MIN) ? K_MIN : baudCtrlReg[DIV_HI:0];
	assign lastBit  = modeReg[CLEN_BIT] ? LAST8 : LAST7;
	assign parSel   = modeReg[PAR_HI:PAR_LO];
	assign txReset  = !powerEn || !modeReg[TXEN_BIT] || !txEnSync_reg;
	assign rxReset  = !powerEn || !modeReg[RXEN_BIT] || !rxEnSync_reg;
	assign rdStatus = regRdEn && hit(regAddr, STATUS_ADDR);
	assign rdBuffer = regRdEn && hit(regAddr, RXB_ADDR);

	// Half-bit and full-bit events, counted separately per path
	assign txHalfDone = baseTick_reg && (txCnt_reg == kEff - 5'h01);
	assign txBitDone  = txHalfDone && txHalf_reg;
	assign rxHalfDone = baseTick_reg && (rxCnt_reg == kEff - 5'h01);
	assign rxBitDone  = rxHalfDone && rxHalf_reg;
	assign txLoad     = regWrEn && hit(regAddr, TXS_ADDR) && !txReset && (txState_reg == TX_IDLE);
	assign rxComplete = !rxReset && (rxState_reg == RX_STOP) && rxBitDone;

	// A 7-bit character arrives in the upper seven bits of the shifter
	assign rxData = modeReg[CLEN_BIT] ? rxShift_reg : {1'b0, rxShift_reg[7:1]};
	always_comb
	begin
		rxErrNew          = 3'h0;
		rxErrNew[OVE_BIT] = rxFullReg;
		rxErrNew[FE_BIT]  = !rxLine;                             // Only the first stop bit is checked
		rxErrNew[PE_BIT]  = ((parSel == PAR_ODD) && !rxPar_reg) || ((parSel == PAR_EVEN) && rxPar_reg);
	end

	// Receive input synchroniser, first stage feeds only the second
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rxSync1_reg <= 1'b1;
			rxSync2_reg <= 1'b1;
		end
		else if (!stopClock)
		begin
			rxSync1_reg <= serialInPin;
			rxSync2_reg <= rxSync1_reg;
		end
	end

	// Mode and baud control registers written by the CPU
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			modeReg     <= MODE_RESET;
			baudCtrlReg <= BAUD_RESET;
		end
		else if (!stopClock)
		begin
			if (regWrEn && hit(regAddr, MODE_ADDR))
				modeReg <= {regWrData[7:1], MODE_RESET[0]};
			if (regWrEn && hit(regAddr, BAUD_ADDR))
				baudCtrlReg <= regWrData;
		end
	end

	// Base clock prescaler, held at zero while power is off to save power
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			presc_reg    <= 8'h00;
			baseTick_reg <= 1'b0;
		end
		else if (!stopClock)
		begin
			if (!powerEn)
			begin
				presc_reg    <= 8'h00;
				baseTick_reg <= 1'b0;
			end
			else
			begin
				presc_reg    <= presc_reg + 8'h01;
				baseTick_reg <= ((presc_reg & tickMask(baudCtrlReg[PRE_HI:PRE_LO])) ==
					tickMask(baudCtrlReg[PRE_HI:PRE_LO]));
			end
		end
	end

	// A set enable takes effect only on a base clock tick; a cleared one acts at once
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			txEnSync_reg <= 1'b0;
			rxEnSync_reg <= 1'b0;
		end
		else if (!stopClock)
		begin
			if (!powerEn)
			begin
				txEnSync_reg <= 1'b0;
				rxEnSync_reg <= 1'b0;
			end
			else if (baseTick_reg)
			begin
				txEnSync_reg <= modeReg[TXEN_BIT];
				rxEnSync_reg <= modeReg[RXEN_BIT];
			end
		end
	end

	// Transmitter: start, data LSB first, optional parity, one or two stops
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			txShiftReg   <= BUF_RESET;
			txState_reg  <= TX_IDLE;
			txCnt_reg    <= 5'h00;
			txHalf_reg   <= 1'b0;
			txBit_reg    <= 3'h0;
			txPar_reg    <= 1'b0;
			serialOutPin <= 1'b1;
			txDone       <= 1'b0;
		end
		else if (!stopClock)
		begin
			txDone <= 1'b0;
			if (txReset)
			begin
				txShiftReg   <= BUF_RESET;
				txState_reg  <= TX_IDLE;
				txCnt_reg    <= 5'h00;
				txHalf_reg   <= 1'b0;
				serialOutPin <= 1'b1;
			end
			else if (txLoad)
			begin
				txShiftReg   <= regWrData;
				txState_reg  <= TX_START;
				txCnt_reg    <= 5'h00;
				txHalf_reg   <= 1'b0;
				txBit_reg    <= 3'h0;
				// Parity is fixed at load time from the data bits in use
				txPar_reg    <= (parSel == PAR_ODD)  ? ~^(regWrData & {modeReg[CLEN_BIT], 7'h7F}) :
				                (parSel == PAR_EVEN) ?  ^(regWrData & {modeReg[CLEN_BIT], 7'h7F}) :
				                1'b0;
				serialOutPin <= 1'b0;
			end
			else if (txState_reg != TX_IDLE)
			begin
				if (baseTick_reg)
					txCnt_reg <= txHalfDone ? 5'h00 : txCnt_reg + 5'h01;
				if (txHalfDone)
					txHalf_reg <= !txHalf_reg;
				if (txBitDone)
				begin
					case (txState_reg)
						TX_START:
						begin
							txState_reg  <= TX_DATA;
							serialOutPin <= txShiftReg[0];
						end
						TX_DATA:
						begin
							txShiftReg <= {1'b1, txShiftReg[7:1]};
							txBit_reg  <= txBit_reg + 3'h1;
							if (txBit_reg != lastBit)
								serialOutPin <= txShiftReg[1];
							else if (parSel != PAR_NONE)
							begin
								txState_reg  <= TX_PARITY;
								serialOutPin <= txPar_reg;
							end
							else
							begin
								txState_reg  <= TX_STOP1;
								serialOutPin <= 1'b1;
							end
						end
						TX_PARITY:
						begin
							txState_reg  <= TX_STOP1;
							serialOutPin <= 1'b1;
						end
						TX_STOP1:
						begin
							txState_reg <= modeReg[STOP_BIT] ? TX_STOP2 : TX_IDLE;
							txDone      <= !modeReg[STOP_BIT];
						end
						TX_STOP2:
						begin
							txState_reg <= TX_IDLE;
							txDone      <= 1'b1;
						end
						default:
							txState_reg <= TX_IDLE;
					endcase
				end
			end
		end
	end

	// Receiver runs on its own counter, aligned to the start edge
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rxState_reg <= RX_IDLE;
			rxCnt_reg   <= 5'h00;
			rxHalf_reg  <= 1'b0;
			rxBit_reg   <= 3'h0;
			rxShift_reg <= BUF_RESET;
			rxPar_reg   <= 1'b0;
			rxDone      <= 1'b0;
		end
		else if (!stopClock)
		begin
			rxDone <= rxComplete;
			if (rxReset)
			begin
				rxState_reg <= RX_IDLE;
				rxCnt_reg   <= 5'h00;
				rxHalf_reg  <= 1'b0;
			end
			else if (rxState_reg == RX_IDLE)
			begin
				// A low level already present counts as a start
				if (!rxLine)
				begin
					rxState_reg <= RX_START;
					rxCnt_reg   <= 5'h00;
					rxHalf_reg  <= 1'b0;
					rxBit_reg   <= 3'h0;
					rxPar_reg   <= 1'b0;
				end
			end
			else
			begin
				if (baseTick_reg)
					rxCnt_reg <= rxHalfDone ? 5'h00 : rxCnt_reg + 5'h01;
				if (rxState_reg == RX_START)
				begin
					// Mid start bit: glitches shorter than half a bit are dropped
					if (rxHalfDone)
					begin
						rxState_reg <= rxLine ? RX_IDLE : RX_DATA;
						rxHalf_reg  <= 1'b0;
					end
				end
				else if (rxHalfDone)
					rxHalf_reg <= !rxHalf_reg;
				if (rxBitDone)
				begin
					case (rxState_reg)
						RX_DATA:
						begin
							rxShift_reg <= {rxLine, rxShift_reg[7:1]};
							rxPar_reg   <= rxPar_reg ^ rxLine;
							rxBit_reg   <= rxBit_reg + 3'h1;
							if (rxBit_reg == lastBit)
								rxState_reg <= (parSel != PAR_NONE) ? RX_PARITY : RX_STOP;
						end
						RX_PARITY:
						begin
							rxPar_reg   <= rxPar_reg ^ rxLine;
							rxState_reg <= RX_STOP;
						end
						RX_STOP:
							rxState_reg <= RX_IDLE;
						default:
							rxState_reg <= RX_IDLE;
					endcase
				end
			end
		end
	end

	// Receive buffer; a new character while unread is dropped
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rxBufReg  <= BUF_RESET;
			rxFullReg <= 1'b0;
		end
		else if (!stopClock)
		begin
			if (!powerEn)
			begin
				rxBufReg  <= BUF_RESET;
				rxFullReg <= 1'b0;
			end
			else if (rxComplete && !rxFullReg)
			begin
				rxBufReg  <= rxData;
				rxFullReg <= 1'b1;
			end
			else if (rdBuffer && !rxComplete)
				rxFullReg <= 1'b0;
		end
	end

	// Error flags: a new error beats a clearing read in the same cycle
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			errReg <= STATUS_RESET;
		else if (!stopClock)
		begin
			if (!powerEn || !modeReg[RXEN_BIT])
				errReg <= STATUS_RESET;
			else
				errReg <= (rdStatus ? STATUS_RESET : errReg) | {5'h00, rxComplete ? rxErrNew : 3'h0};
		end
	end

	// Read data port; transmit register reads as zero
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			regRdData <= READ_ZERO;
		else if (!stopClock && regRdEn)
		begin
			case (regAddr)
				MODE_ADDR:   regRdData <= modeReg;
				BAUD_ADDR:   regRdData <= baudCtrlReg;
				STATUS_ADDR: regRdData <= errReg;
				RXB_ADDR:    regRdData <= rxBufReg;
				default:     regRdData <= READ_ZERO;
			endcase
		end
	end

	// Cycles since the current transmit bit began; saturates, only a floor is needed
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			outAge_reg <= 8'h00;
		else if (!stopClock)
		begin
			if (txReset || txLoad || (txBitDone && (txState_reg != TX_IDLE)))
				outAge_reg <= 8'h00;
			else if (!outAge_reg[7])
				outAge_reg <= outAge_reg + 8'h01;
		end
	end

	sequence s_two_stop_end;
		!stopClock && !txReset && txState_reg == TX_STOP1 && txBitDone && modeReg[STOP_BIT];
	endsequence

	sequence s_new_char;
		!stopClock && rxComplete && !rxFullReg && !modeReg[CLEN_BIT];
	endsequence

	a_buffer_power_fill: assert property (@(posedge core_clk) disable iff (rst)
		(!powerEn && !stopClock) |=> (rxBufReg == BUF_RESET))
		else $error("receive buffer not all ones while power is off");

	a_txshift_disable_fill: assert property (@(posedge core_clk) disable iff (rst)
		(!modeReg[TXEN_BIT] && !stopClock) |=> (txShiftReg == BUF_RESET) && serialOutPin)
		else $error("transmit register not all ones after disable");

	a_idle_line_high: assert property (@(posedge core_clk) disable iff (rst)
		(txState_reg == TX_IDLE) |-> serialOutPin)
		else $error("serial output low while transmitter idle");

	a_stop_holds_out: assert property (@(posedge core_clk) disable iff (rst)
		stopClock |=> $stable(serialOutPin) && $stable(rxBufReg))
		else $error("state moved while the clock was stopped");

	a_overrun_keeps_buf: assert property (@(posedge core_clk) disable iff (rst)
		(!stopClock && rxComplete && rxFullReg) |=> $stable(rxBufReg) && errReg[OVE_BIT])
		else $error("overrun character overwrote the receive buffer");

	a_seven_bit_top: assert property (@(posedge core_clk) disable iff (rst)
		s_new_char |=> !rxBufReg[7] && rxFullReg)
		else $error("top bit set on a seven bit character");

	a_load_starts_tx: assert property (@(posedge core_clk) disable iff (rst)
		(txLoad && !stopClock) |=> !serialOutPin && (txState_reg == TX_START) && (txShiftReg == $past(regWrData)))
		else $error("write to transmit register did not start a character");

	a_enable_on_tick: assert property (@(posedge core_clk) disable iff (rst)
		$changed(txEnSync_reg) && $past(powerEn) |-> $past(baseTick_reg))
		else $error("transmit enable changed off a base tick");

	a_two_stop_bits: assert property (@(posedge core_clk) disable iff (rst)
		s_two_stop_end |=> (txState_reg == TX_STOP2) && serialOutPin && !txDone)
		else $error("second stop bit not sent");

	a_rate_floor: assert property (@(posedge core_clk) disable iff (rst)
		(!stopClock && !txReset && txBitDone && (txState_reg != TX_IDLE)) |->
			((outAge_reg + 8'h01) >= {2'h0, K_MIN, 1'b0}))
		else $error("transmit bit shorter than the maximum rate allows");

endmodule

// File: bench/remote_transceiver.sv
// Remote serial transceiver model facing the port's two data lines
`timescale 1ns/1ns
module remote_transceiver
	import async_serial_port_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic portOut,
	output logic      portIn
);
	int         bitCycles = 40;
	int         nBits     = 8;
	logic [1:0] parMode   = PAR_NONE;
	logic [7:0] gotByte;
	logic       gotPar;
	logic       gotStop;
	int         gotCount  = 0;

	// Line rests at mark level between frames
	initial portIn = 1'b1;

	// Parity over the sent bits; zero parity is always 0
	function automatic logic parOf(input logic [7:0] d);
		logic p;
		p = ^(nBits == 8 ? d : {1'b0, d[6:0]});
		case (parMode)
			PAR_ODD:  parOf = ~p;
			PAR_EVEN: parOf = p;
			default:  parOf = 1'b0;
		endcase
	endfunction

	// Receiver samples mid bit; a frozen port simply yields a garbage frame
	initial
	begin
		forever
		begin
			@(negedge portOut);
			gotByte = 8'h00;
			gotPar  = 1'b0;
			repeat (bitCycles / 2) @(posedge core_clk);
			for (int i = 0; i < nBits; i++)
			begin
				repeat (bitCycles) @(posedge core_clk);
				gotByte[i] = portOut;
			end
			if (parMode != PAR_NONE)
			begin
				repeat (bitCycles) @(posedge core_clk);
				gotPar = portOut;
			end
			repeat (bitCycles) @(posedge core_clk);
			gotStop = portOut;
			gotCount++;
		end
	end

	// One frame, single stop bit; badPar inverts the parity bit on demand
	task automatic send(input logic [7:0] d, input logic badPar);
		@(negedge core_clk);
		portIn = 1'b0;
		repeat (bitCycles) @(negedge core_clk);
		for (int i = 0; i < nBits; i++)
		begin
			portIn = d[i];
			repeat (bitCycles) @(negedge core_clk);
		end
		if (parMode != PAR_NONE)
		begin
			portIn = parOf(d) ^ badPar;
			repeat (bitCycles) @(negedge core_clk);
		end
		portIn = 1'b1;
		repeat (bitCycles) @(negedge core_clk);
	endtask
endmodule

// File: bench/async_serial_port_tb_top.sv
// Self-checking bench for the asynchronous serial port
`timescale 1ns/1ns
module async_serial_port_tb_top
	import async_serial_port_pkg::*;
;
	logic       core_clk;
	logic       rst;
	logic       stopClock;
	logic [7:0] regAddr;
	logic       regWrEn;
	logic       regRdEn;
	logic [7:0] regWrData;
	logic [7:0] regRdData;
	logic       serialInPin;
	logic       serialOutPin;
	logic       txDone;
	logic       rxDone;
	int         miscompares = 0;
	int         checks      = 0;
	int         rxCount     = 0;
	logic [7:0] rd;

	async_serial_port DUT (
		.core_clk    (core_clk),
		.rst         (rst),
		.stopClock   (stopClock),
		.regAddr     (regAddr),
		.regWrEn     (regWrEn),
		.regRdEn     (regRdEn),
		.regWrData   (regWrData),
		.regRdData   (regRdData),
		.serialInPin (serialInPin),
		.serialOutPin(serialOutPin),
		.txDone      (txDone),
		.rxDone      (rxDone)
	);

	remote_transceiver partner (
		.core_clk(core_clk),
		.portOut (serialOutPin),
		.portIn  (serialInPin)
	);

	// 25 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Count received characters so short pulses are never missed by a task
	always @(posedge core_clk)
	begin
		if (rxDone === 1'b1)
			rxCount <= rxCount + 1;
	end

	task automatic complete_run();
		$display("Checks %0d, miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask

	task automatic timeout(input string name);
		$display("Error %s expected pulse seen timeout", name);
		miscompares++;
		complete_run();
	endtask

	// Strobes are held across exactly one rising edge
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge core_clk);
		regWrEn = 1'b0;
	endtask

	task automatic read_check(input string name, input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge core_clk);
		regRdEn = 1'b0;
		@(negedge core_clk);
		check(name, exp, regRdData);
	endtask

	function automatic logic [7:0] modeVal(input logic en, input logic [1:0] par, input logic c8, input logic two);
		modeVal = {1'b1, en, en, par, c8, two, 1'b1};
	endfunction

	function automatic logic expPar(input logic [7:0] d, input logic [1:0] par);
		expPar = (par == PAR_ODD) ? ~^d : (par == PAR_EVEN) ? ^d : 1'b0;
	endfunction

	// Enables are dropped in the same write that sets the format and raised only after power
	task automatic cfg(input logic [7:0] baud, input logic [1:0] par, input logic c8, input logic two, input int len);
		reg_write(MODE_ADDR, modeVal(1'b0, par, c8, two));
		reg_write(BAUD_ADDR, baud);
		repeat (8) @(negedge core_clk);
		reg_write(MODE_ADDR, modeVal(1'b1, par, c8, two));
		repeat (8) @(negedge core_clk);
		partner.bitCycles = len;
		partner.nBits = c8 ? 8 : 7;
		partner.parMode = par;
	endtask

	task automatic tx_check(input logic [7:0] d, input logic [1:0] par, input logic c8, input logic two, input int len);
		int         n;
		int         frame;
		logic [7:0] m;
		m = c8 ? d : {1'b0, d[6:0]};
		frame = (2 + (c8 ? 8 : 7) + (par != PAR_NONE) + two) * len;
		reg_write(TXS_ADDR, d);
		n = 1;
		while (txDone !== 1'b1)
		begin
			if (n > frame + 8)
				timeout("txDone");
			@(negedge core_clk);
			n++;
		end
		check("frame length", 1'b1, n >= frame && n <= frame + 2);
		check("tx data", m, partner.gotByte);
		check("tx parity", expPar(m, par), partner.gotPar);
		check("tx stop", 1'b1, partner.gotStop);
	endtask

	task automatic wait_rx(input int target);
		int n;
		n = 0;
		while (rxCount < target)
		begin
			if (n > 100)
				timeout("rxDone");
			@(negedge core_clk);
			n++;
		end
	endtask

	task automatic t_reset();
		read_check("buffer reset", RXB_ADDR, BUF_RESET);
		read_check("transmit read", TXS_ADDR, READ_ZERO);
		read_check("status reset", STATUS_ADDR, STATUS_RESET);
		check("idle line", 1'b1, serialOutPin);
		$display("Test reset done");
	endtask

	// Every parity code, both lengths and both stop settings
	task automatic t_tx();
		for (int i = 0; i < 4; i++)
		begin
			cfg(8'h00, 2'(i), i[0], i[1], 40);
			tx_check(8'h96 ^ 8'(i), 2'(i), i[0], i[1], 40);
		end
		$display("Test transmit formats done");
	endtask

	// Divisor below the clamp, above it, and a prescaled base clock
	task automatic t_rate();
		logic [7:0] bauds [3] = '{8'h01, 8'h19, 8'h34};
		int         lens [3]  = '{40, 50, 80};
		for (int i = 0; i < 3; i++)
		begin
			cfg(bauds[i], PAR_NONE, 1'b1, 1'b0, lens[i]);
			tx_check(8'h5A, PAR_NONE, 1'b1, 1'b0, lens[i]);
		end
		$display("Test rates done");
	endtask

	// Wrong parity bit: flagged only for odd and even
	task automatic t_rx();
		logic [7:0] d;
		int         c;
		for (int i = 0; i < 4; i++)
		begin
			cfg(8'h00, 2'(i), i[0], 1'b0, 40);
			d = 8'hC3 ^ 8'(i);
			// The character completes mid stop bit, before the send returns
			c = rxCount;
			partner.send(d, 1'b1);
			wait_rx(c + 1);
			read_check("rx status", STATUS_ADDR, i >= 2 ? 8'h04 : 8'h00);
			read_check("rx data", RXB_ADDR, i[0] ? d : {1'b0, d[6:0]});
		end
		$display("Test receive formats done");
	endtask

	task automatic t_overrun();
		int c;
		cfg(8'h00, PAR_NONE, 1'b1, 1'b0, 40);
		c = rxCount;
		partner.send(8'h11, 1'b0);
		partner.send(8'h22, 1'b0);
		wait_rx(c + 2);
		read_check("overrun data", RXB_ADDR, 8'h11);
		read_check("overrun flag", STATUS_ADDR, 8'h01);
		reg_write(RXB_ADDR, 8'h5A);
		read_check("buffer write", RXB_ADDR, 8'h11);
		$display("Test overrun done");
	endtask

	task automatic t_duplex();
		int c;
		c = rxCount;
		fork
			partner.send(8'h3C, 1'b0);
			tx_check(8'hC3, PAR_NONE, 1'b1, 1'b0, 40);
		join
		wait_rx(c + 1);
		read_check("duplex data", RXB_ADDR, 8'h3C);
		$display("Test duplex done");
	endtask

	// Freeze mid-frame on a low data bit, then reinitialise
	task automatic t_stop();
		int   changes;
		logic held;
		changes = 0;
		reg_write(TXS_ADDR, 8'hF0);
		repeat (100) @(negedge core_clk);
		stopClock = 1'b1;
		@(negedge core_clk);
		held = serialOutPin;
		repeat (200)
		begin
			@(negedge core_clk);
			if (serialOutPin !== held || txDone !== 1'b0)
				changes++;
		end
		check("held level", 1'b0, held);
		check("frozen changes", 8'h00, 8'(changes));
		stopClock = 1'b0;
		reg_write(MODE_ADDR, MODE_RESET);
		repeat (600) @(negedge core_clk);
		check("line after reinit", 1'b1, serialOutPin);
		$display("Test clock stop done");
	endtask

	// Power off clears a pending parity error and the buffer
	task automatic t_power();
		cfg(8'h00, PAR_ODD, 1'b1, 1'b0, 40);
		partner.send(8'h77, 1'b1);
		reg_write(MODE_ADDR, MODE_RESET);
		read_check("power buffer", RXB_ADDR, BUF_RESET);
		read_check("power status", STATUS_ADDR, STATUS_RESET);
		$display("Test power off done");
	endtask

	initial
	begin
		rst = 1'b1;
		stopClock = 1'b0;
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regWrData = 8'h00;
		repeat (8) @(negedge core_clk);
		rst = 1'b0;
		t_reset();
		t_tx();
		t_rate();
		t_rx();
		t_overrun();
		t_duplex();
		t_stop();
		t_power();
		complete_run();
	end
endmodule
